// ==== src/drl_loader.sv ====
// Purpose: Two-wire master that reads the descriptor override image
// Assumes: Serial ROM on open-drain data and clock pins with pull-ups
// Notes:   One load per reset only
`timescale 1ns/10ps
module drl_loader #(
    parameter int unsigned QUARTER = drl_pkg::QUARTER_CYC,
    parameter int unsigned DATA_W  = 8
) (
    input  wire logic                      clock,
    input  wire logic                      reset_n,
    input  wire logic                      power_select,
    input  wire logic                      host_mode,
    input  wire logic                      rom_serial_data_in,
    output logic                           rom_serial_data_out,
    output logic                           rom_serial_data_oe,
    input  wire logic                      rom_serial_clock_in,
    output logic                           rom_serial_clock_out,
    output logic                           rom_serial_clock_oe,
    output logic                           pullup_enable,
    output logic                           usb_nack_all,
    output logic                           load_done,
    output logic                           override_valid,
    output logic [15:0]                    vendor_id,
    output logic [15:0]                    product_id,
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output logic [DATA_W-1:0]              out_byte,
    output logic [drl_pkg::IDX_W-1:0]      out_index,
    output drl_pkg::drl_field_t            out_field,
    output logic                           out_unicode
);
    import drl_pkg::*;

    typedef enum {
        DRL_SYNC,
        DRL_START,
        DRL_TX,
        DRL_RX,
        DRL_STOP,
        DRL_DONE
    } drl_state_t;

    localparam int unsigned ENT_W = DATA_W + IDX_W;

    function automatic drl_field_t field_of(input logic [IDX_W-1:0] i);
        if (i < IDX_W'(PID_OFS))       field_of = DRL_FLD_VID;
        else if (i < IDX_W'(PSTR_OFS)) field_of = DRL_FLD_PID;
        else if (i < IDX_W'(VSTR_OFS)) field_of = DRL_FLD_PSTR;
        else if (i < IDX_W'(PWR_OFS))  field_of = DRL_FLD_VSTR;
        else if (i < IDX_W'(MAXP_OFS)) field_of = DRL_FLD_PWR;
        else if (i < IDX_W'(HID_OFS))  field_of = DRL_FLD_MAXP;
        else                           field_of = DRL_FLD_HID;
    endfunction

    // Pin synchronisers: stage 1 is read only by stage 2
    logic [3:0] sy1_r;
    logic [3:0] sy2_r;
    logic       psel_s;
    logic       host_s;
    logic       sda_s;
    logic       scl_s;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sy1_r <= 4'hF;
            sy2_r <= 4'hF;
        end else begin
            sy1_r <= {power_select, host_mode, rom_serial_data_in,
                      rom_serial_clock_in};
            sy2_r <= sy1_r;
        end
    end

    assign psel_s = sy2_r[3];
    assign host_s = sy2_r[2];
    assign sda_s  = sy2_r[1];
    assign scl_s  = sy2_r[0];

    // Two-entry buffer between the serial engine and the consumer
    logic [ENT_W-1:0] mem_r [2];
    logic [ENT_W-1:0] mem_nxt [2];
    logic             wp_r;
    logic             wp_nxt;
    logic             rp_r;
    logic             rp_nxt;
    logic [1:0]       cnt_r;
    logic [1:0]       cnt_nxt;
    logic             in_ready;
    logic             push;
    logic [ENT_W-1:0] push_data;
    logic             pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = push_data;
            wp_nxt = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        case ({push, pop})
            2'b10:   cnt_nxt = cnt_r + 2'h1;
            2'b01:   cnt_nxt = cnt_r - 2'h1;
            default: cnt_nxt = cnt_r;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            wp_r     <= 1'b0;
            rp_r     <= 1'b0;
            cnt_r    <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign out_byte  = mem_r[rp_r][ENT_W-1:IDX_W];
    assign out_index = mem_r[rp_r][IDX_W-1:0];
    assign out_field = field_of(out_index);
    // String bytes go to the host as Unicode: zero high byte added
    assign out_unicode = (out_field == DRL_FLD_PSTR) ||
                         (out_field == DRL_FLD_VSTR);

    // Serial sequencer
    drl_state_t       st_r;
    drl_state_t       st_nxt;
    logic [15:0]      tick_r;
    logic [15:0]      tick_nxt;
    logic [1:0]       ph_r;
    logic [1:0]       ph_nxt;
    logic [3:0]       bit_r;
    logic [3:0]       bit_nxt;
    logic [7:0]       sh_r;
    logic [7:0]       sh_nxt;
    logic [1:0]       step_r;
    logic [1:0]       step_nxt;
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_nxt;
    logic             sda_lo_r;
    logic             sda_lo_nxt;
    logic             scl_lo_r;
    logic             scl_lo_nxt;
    logic             ok_r;
    logic             ok_nxt;
    logic             done_r;
    logic             done_nxt;
    logic [15:0]      vid_r;
    logic [15:0]      vid_nxt;
    logic [15:0]      pid_r;
    logic [15:0]      pid_nxt;
    logic             adv;
    logic             hold;
    logic             last;

    // A slave stretching the clock holds the high phases
    assign hold = !scl_lo_r && !scl_s;
    assign adv  = !hold && (tick_r == 16'(QUARTER - 1));
    assign last = (idx_r == IDX_W'(ROM_BYTES - 1));
    // The final bit joins the byte in the same cycle it is pushed
    assign push_data = {sda_s, sh_r[7:1], idx_r};

    always_comb begin
        st_nxt   = st_r;
        tick_nxt = hold ? 16'h0000 : (adv ? 16'h0000 : tick_r + 16'h0001);
        ph_nxt   = ph_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        step_nxt = step_r;
        idx_nxt  = idx_r;
        ok_nxt   = ok_r;
        done_nxt = done_r;
        vid_nxt  = vid_r;
        pid_nxt  = pid_r;
        push     = 1'b0;
        if (adv) begin
            ph_nxt = ph_r + 2'h1;
        end
        case (st_r)
            DRL_SYNC: begin
                // Straps are judged only once the synchronisers have filled
                if (tick_r == 16'(SYNC_WAIT_CYC)) begin
                    tick_nxt = 16'h0000;
                    ph_nxt   = 2'h0;
                    if (psel_s && host_s) begin
                        st_nxt = DRL_START;
                    end else begin
                        st_nxt  = DRL_DONE;
                        done_nxt = 1'b1;
                    end
                end
            end
            DRL_START: begin
                if (adv && ph_r == 2'h3) begin
                    st_nxt  = DRL_TX;
                    bit_nxt = 4'h0;
                    sh_nxt  = (step_r == 2'h0) ? DEV_ADDR_WR
                                               : DEV_ADDR_RD;
                    step_nxt = (step_r == 2'h0) ? 2'h0 : 2'h3;
                end
            end
            DRL_TX: begin
                if (adv && ph_r == 2'h3) begin
                    if (bit_r != 4'h8) begin
                        sh_nxt  = {sh_r[6:0], 1'b0};
                        bit_nxt = bit_r + 4'h1;
                    end else if (sda_s) begin
                        // No answer from the ROM: keep built-in data
                        st_nxt = DRL_STOP;
                        ok_nxt = 1'b0;
                    end else begin
                        bit_nxt = 4'h0;
                        case (step_r)
                            2'h0: begin
                                sh_nxt   = ROM_START;
                                step_nxt = 2'h1;
                            end
                            2'h1: begin
                                st_nxt   = DRL_START;
                                step_nxt = 2'h2;
                            end
                            default: begin
                                st_nxt  = DRL_RX;
                                idx_nxt = '0;
                            end
                        endcase
                    end
                end
            end
            DRL_RX: begin
                if (adv && ph_r == 2'h3) begin
                    if (bit_r == 4'h7) begin
                        // Stall with the clock high until the buffer has room
                        if (in_ready) begin
                            push    = 1'b1;
                            bit_nxt = 4'h8;
                        end else begin
                            ph_nxt   = ph_r;
                            tick_nxt = tick_r;
                        end
                    end else if (bit_r == 4'h8) begin
                        if (last) begin
                            st_nxt = DRL_STOP;
                            ok_nxt = 1'b1;
                        end else begin
                            idx_nxt = idx_r + IDX_W'(1);
                            bit_nxt = 4'h0;
                        end
                    end else begin
                        bit_nxt = bit_r + 4'h1;
                    end
                    // A stalled bit 7 is taken once, when the buffer frees
                    if ((bit_r != 4'h8) && !((bit_r == 4'h7) && !in_ready))
                    begin
                        // First bit on the wire is bit 0
                        sh_nxt = {sda_s, sh_r[7:1]};
                    end
                end
                if (push) begin
                    // Identifiers arrive low byte first
                    case (idx_r)
                        IDX_W'(VID_OFS):     vid_nxt[7:0]  = sda_s ? {1'b1,
                            sh_r[7:1]} : {1'b0, sh_r[7:1]};
                        IDX_W'(VID_OFS + 1): vid_nxt[15:8] = {sda_s,
                            sh_r[7:1]};
                        IDX_W'(PID_OFS):     pid_nxt[7:0]  = {sda_s,
                            sh_r[7:1]};
                        IDX_W'(PID_OFS + 1): pid_nxt[15:8] = {sda_s,
                            sh_r[7:1]};
                        default: ;
                    endcase
                end
            end
            DRL_STOP: begin
                if (adv && ph_r == 2'h3) begin
                    st_nxt   = DRL_DONE;
                    done_nxt = 1'b1;
                end
            end
            DRL_DONE: begin
                // Held until the next reset: one load only
                tick_nxt = 16'h0000;
                ph_nxt   = 2'h0;
            end
            default: st_nxt = DRL_DONE;
        endcase

        // Open-drain drive for the phase being entered
        case (st_nxt)
            DRL_START: begin
                scl_lo_nxt = (ph_nxt == 2'h0);
                sda_lo_nxt = (ph_nxt[1] == 1'b1);
            end
            DRL_TX: begin
                scl_lo_nxt = !ph_nxt[1];
                sda_lo_nxt = (bit_nxt != 4'h8) && !sh_nxt[7];
            end
            DRL_RX: begin
                scl_lo_nxt = !ph_nxt[1];
                // Master ACKs each byte, NACKs the last one
                sda_lo_nxt = (bit_nxt == 4'h8) && !last;
            end
            DRL_STOP: begin
                scl_lo_nxt = (ph_nxt == 2'h0);
                sda_lo_nxt = (ph_nxt != 2'h3);
            end
            default: begin
                scl_lo_nxt = 1'b0;
                sda_lo_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_r     <= DRL_SYNC;
            tick_r   <= 16'h0000;
            ph_r     <= 2'h0;
            bit_r    <= 4'h0;
            sh_r     <= 8'h00;
            step_r   <= 2'h0;
            idx_r    <= '0;
            sda_lo_r <= 1'b0;
            scl_lo_r <= 1'b0;
            ok_r     <= 1'b0;
            done_r   <= 1'b0;
            vid_r    <= ID_RESET;
            pid_r    <= ID_RESET;
        end else begin
            st_r     <= st_nxt;
            tick_r   <= tick_nxt;
            ph_r     <= ph_nxt;
            bit_r    <= bit_nxt;
            sh_r     <= sh_nxt;
            step_r   <= step_nxt;
            idx_r    <= idx_nxt;
            sda_lo_r <= sda_lo_nxt;
            scl_lo_r <= scl_lo_nxt;
            ok_r     <= ok_nxt;
            done_r   <= done_nxt;
            vid_r    <= vid_nxt;
            pid_r    <= pid_nxt;
        end
    end

    assign rom_serial_data_out  = 1'b0;
    assign rom_serial_data_oe   = sda_lo_r;
    assign rom_serial_clock_out = 1'b0;
    assign rom_serial_clock_oe  = scl_lo_r;
    assign load_done      = done_r;
    assign override_valid = done_r && ok_r;
    assign pullup_enable  = done_r;
    assign usb_nack_all   = !done_r;
    assign vendor_id      = vid_r;
    assign product_id     = pid_r;
endmodule

// ==== src/drl_pkg.sv ====
// Purpose: Shared constants for the descriptor ROM loader
// Assumes: 100 MHz system clock, crystal nominally 12 MHz
// Notes:   Image layout and two-wire framing constants
package drl_pkg;
    localparam int unsigned CLK_FREQ_KHZ  = 100000;
    localparam int unsigned XTAL_FREQ_KHZ = 12000;
    localparam int unsigned SCL_DIV       = 384;
    // One serial clock period, in system clocks, split in four phases
    localparam int unsigned SCL_PERIOD_CYC =
        (SCL_DIV * CLK_FREQ_KHZ) / XTAL_FREQ_KHZ;
    localparam int unsigned QUARTER_CYC   = SCL_PERIOD_CYC / 4;
    localparam int unsigned SYNC_WAIT_CYC = 3;

    localparam logic [7:0] DEV_ADDR_WR = 8'hA0;
    localparam logic [7:0] DEV_ADDR_RD = 8'hA1;
    localparam logic [7:0] ROM_START   = 8'h00;

    localparam int unsigned VID_LEN   = 2;
    localparam int unsigned PID_LEN   = 2;
    localparam int unsigned PSTR_LEN  = 16;
    localparam int unsigned VSTR_LEN  = 32;
    localparam int unsigned PWR_LEN   = 1;
    localparam int unsigned MAXP_LEN  = 1;
    localparam int unsigned HID_LEN   = 3;
    localparam int unsigned VID_OFS   = 0;
    localparam int unsigned PID_OFS   = VID_OFS + VID_LEN;
    localparam int unsigned PSTR_OFS  = PID_OFS + PID_LEN;
    localparam int unsigned VSTR_OFS  = PSTR_OFS + PSTR_LEN;
    localparam int unsigned PWR_OFS   = VSTR_OFS + VSTR_LEN;
    localparam int unsigned MAXP_OFS  = PWR_OFS + PWR_LEN;
    localparam int unsigned HID_OFS   = MAXP_OFS + MAXP_LEN;
    localparam int unsigned ROM_BYTES = HID_OFS + HID_LEN;
    localparam int unsigned IDX_W     = 6;

    localparam logic [15:0] ID_RESET  = 16'h0000;

    typedef enum logic [2:0] {
        DRL_FLD_VID,
        DRL_FLD_PID,
        DRL_FLD_PSTR,
        DRL_FLD_VSTR,
        DRL_FLD_PWR,
        DRL_FLD_MAXP,
        DRL_FLD_HID
    } drl_field_t;
endpackage

// ==== testbench/drl_loader_bench.sv ====
// Purpose: Self-checking bench for the descriptor loader
// Assumes: Shortened serial clock through QUARTER
// Notes:   Lines resolved open drain with pull-ups
`timescale 1ns/10ps
module drl_loader_bench;
    import drl_pkg::*;
    localparam int unsigned QUARTER = 4;
    localparam int unsigned DATA_W  = 8;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic power_select = 1'b0;
    logic host_mode = 1'b0;
    logic out_ready = 1'b0;
    logic nack_addr = 1'b0;
    logic slow = 1'b0;
    wire  sda, scl;
    logic sd_out, sd_oe, sc_out, sc_oe, rom_sd_oe, rom_sc_oe;
    logic pullup_enable, usb_nack_all, load_done, override_valid;
    logic out_valid, out_unicode;
    logic [15:0] vendor_id, product_id;
    logic [7:0] out_byte;
    logic [IDX_W-1:0] out_index;
    drl_field_t out_field;
    int err_total = 0;
    int check_count = 0;
    int s0;
    assign sda = !(sd_oe && !sd_out) && !rom_sd_oe;
    assign scl = !(sc_oe && !sc_out) && !rom_sc_oe;
    always #5 clock = ~clock;
    drl_loader #(.QUARTER(QUARTER), .DATA_W(DATA_W)) DUT (
        .clock(clock), .reset_n(reset_n), .power_select(power_select),
        .host_mode(host_mode), .rom_serial_data_in(sda),
        .rom_serial_data_out(sd_out), .rom_serial_data_oe(sd_oe),
        .rom_serial_clock_in(scl), .rom_serial_clock_out(sc_out),
        .rom_serial_clock_oe(sc_oe), .pullup_enable(pullup_enable),
        .usb_nack_all(usb_nack_all), .load_done(load_done),
        .override_valid(override_valid), .vendor_id(vendor_id),
        .product_id(product_id), .out_valid(out_valid),
        .out_ready(out_ready), .out_byte(out_byte),
        .out_index(out_index), .out_field(out_field),
        .out_unicode(out_unicode));
    drl_rom_model ROM (.scl(scl), .sda(sda), .nack_addr(nack_addr),
        .slow(slow), .sda_oe(rom_sd_oe), .scl_oe(rom_sc_oe));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset(input logic ps, input logic hm);
        @(posedge clock);
        reset_n <= 1'b0;
        power_select <= ps;
        host_mode <= hm;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        s0 = ROM.starts;
    endtask
    task automatic wait_done(input int lim);
        int n = 0;
        while (load_done !== 1'b1 && n < lim) begin
            @(posedge clock);
            n++;
        end
    endtask
    function automatic drl_field_t exp_field(input int i);
        if (i >= HID_OFS) return DRL_FLD_HID;
        if (i >= MAXP_OFS) return DRL_FLD_MAXP;
        if (i >= PWR_OFS) return DRL_FLD_PWR;
        if (i >= VSTR_OFS) return DRL_FLD_VSTR;
        if (i >= PSTR_OFS) return DRL_FLD_PSTR;
        if (i >= PID_OFS) return DRL_FLD_PID;
        return DRL_FLD_VID;
    endfunction
    task automatic t_straps;
        for (int k = 0; k < 3; k++) begin
            do_reset(k[1], k[0]);
            wait_done(50);
            chk(load_done, 1);
            chk(override_valid, 0);
            chk(pullup_enable, 1);
            repeat (200) @(posedge clock);
            chk(ROM.starts - s0, 0);
        end
    endtask
    // Consumer stalls first so the buffer fills and the link waits
    task automatic t_load;
        int n;
        slow <= 1'b1;
        do_reset(1'b1, 1'b1);
        repeat (3000) @(posedge clock);
        chk(usb_nack_all, 1);
        chk(pullup_enable, 0);
        for (int i = 0; i < ROM_BYTES; i++) begin
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (out_valid !== 1'b1 && n < 4000);
            chk(out_byte, ROM.img(i));
            chk(out_index, i);
            chk(out_field, exp_field(i));
            chk(out_unicode, i >= PSTR_OFS && i < PWR_OFS);
            if (i % 7 == 3) repeat (50) @(posedge clock);
            out_ready <= 1'b1;
            @(posedge clock);
            out_ready <= 1'b0;
        end
        wait_done(2000);
        chk(override_valid, 1);
        chk(vendor_id, {ROM.img(1), ROM.img(0)});
        chk(product_id, {ROM.img(3), ROM.img(2)});
        chk(pullup_enable, 1);
        chk(usb_nack_all, 0);
        chk(ROM.wr_addr, DEV_ADDR_WR);
        chk(ROM.word_addr, ROM_START);
        chk(ROM.mack, 0);
        chk(ROM.active, 0);
        repeat (500) @(posedge clock);
        chk(ROM.starts - s0, 2);
        slow <= 1'b0;
    endtask
    task automatic t_nack;
        nack_addr <= 1'b1;
        do_reset(1'b1, 1'b1);
        wait_done(2000);
        chk(load_done, 1);
        chk(override_valid, 0);
        chk(ROM.active, 0);
        nack_addr <= 1'b0;
    endtask
    initial begin
        do_reset(1'b0, 1'b0);
        t_straps;
        t_load;
        t_nack;
        test_done;
    end
    // Whole run is near 25k cycles
    initial begin
        #1000000;
        err_total++;
        test_done;
    end
endmodule
bind drl_loader drl_loader_chk #(.QUARTER(QUARTER), .DATA_W(DATA_W)) u_chk (
    .clock(clock), .reset_n(reset_n), .power_select(power_select),
    .host_mode(host_mode), .rom_serial_data_out(rom_serial_data_out),
    .rom_serial_data_oe(rom_serial_data_oe),
    .rom_serial_clock_out(rom_serial_clock_out),
    .rom_serial_clock_oe(rom_serial_clock_oe),
    .pullup_enable(pullup_enable), .usb_nack_all(usb_nack_all),
    .load_done(load_done), .override_valid(override_valid),
    .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte),
    .out_index(out_index), .out_field(out_field),
    .out_unicode(out_unicode));

// ==== testbench/drl_loader_chk.sv ====
// Purpose: Concurrent checks on the descriptor loader ports
// Assumes: Straps change only while reset is held
// Notes:   Bound to every loader instance from the bench top
`timescale 1ns/10ps
module drl_loader_chk #(
    parameter int unsigned QUARTER = 4,
    parameter int unsigned DATA_W  = 8
) (
    input wire logic                 clock,
    input wire logic                 reset_n,
    input wire logic                 power_select,
    input wire logic                 host_mode,
    input wire logic                 rom_serial_data_out,
    input wire logic                 rom_serial_data_oe,
    input wire logic                 rom_serial_clock_out,
    input wire logic                 rom_serial_clock_oe,
    input wire logic                 pullup_enable,
    input wire logic                 usb_nack_all,
    input wire logic                 load_done,
    input wire logic                 override_valid,
    input wire logic                 out_valid,
    input wire logic                 out_ready,
    input wire logic [DATA_W-1:0]    out_byte,
    input wire logic [drl_pkg::IDX_W-1:0] out_index,
    input drl_pkg::drl_field_t       out_field,
    input wire logic                 out_unicode
);
    import drl_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_pop;
        out_valid && out_ready;
    endsequence
    sequence s_hold;
        out_valid && !out_ready;
    endsequence
    a_pullup_wait: assert property (!load_done |-> !pullup_enable)
        else $error("pull-up enabled before load end");
    a_nack_pending: assert property (usb_nack_all == !load_done)
        else $error("nack flag disagrees with load state");
    a_done_sticky: assert property (load_done |=> load_done)
        else $error("load done dropped without reset");
    a_strap_gate: assert property ((!power_select || !host_mode) |->
        !rom_serial_clock_oe && !rom_serial_data_oe)
        else $error("bus driven with override disabled");
    a_override_gate: assert property ($rose(override_valid) |->
        power_select && host_mode)
        else $error("override with straps low");
    a_override_done: assert property (override_valid |-> load_done)
        else $error("override before load end");
    a_bus_free: assert property (load_done |->
        !rom_serial_clock_oe && !rom_serial_data_oe)
        else $error("bus held after load end");
    a_open_drain: assert property (!rom_serial_data_out &&
        !rom_serial_clock_out)
        else $error("pin driven high");
    a_hold_byte: assert property (s_hold |=> out_valid &&
        $stable(out_byte) && $stable(out_index))
        else $error("stalled byte changed");
    a_index_step: assert property (s_pop ##1 out_valid |->
        out_index == 6'($past(out_index) + 6'h01))
        else $error("byte index skipped");
    a_unicode_str: assert property (out_valid |-> out_unicode ==
        (out_field inside {DRL_FLD_PSTR, DRL_FLD_VSTR}))
        else $error("unicode flag wrong for field");
endmodule

// ==== testbench/drl_rom_model.sv ====
// Purpose: Behavioural two-wire descriptor ROM on pulled-up lines
// Assumes: Open drain; released lines read high
// Notes:   Optional clock stretching and address refusal
`timescale 1ns/10ps
module drl_rom_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_addr,
    input wire logic slow,
    output logic     sda_oe,
    output logic     scl_oe
);
    import drl_pkg::*;
    logic [7:0] sh, adr, wr_addr, word_addr, cur;
    int         ptr, bitn, nbyte, starts;
    logic       rx, mack, active, done;
    initial begin
        sda_oe = 1'b0;
        scl_oe = 1'b0;
        starts = 0;
        active = 1'b0;
    end
    // Plain ASCII strings, bus-powered attributes
    // Same image a serial-port host would load on ROM-less parts
    function automatic logic [7:0] img(input int i);
        if (i >= PSTR_OFS && i < PWR_OFS) return 8'h41 + 8'(i % 26);
        if (i == PWR_OFS) return 8'h80;
        if (i == MAXP_OFS) return 8'h32;
        return 8'(i) * 8'h25 + 8'h15;
    endfunction
    // Data may move at the very instant the clock falls (zero hold):
    // judge start and stop only once the clock has settled
    always @(negedge sda) begin
        #1;
        if (scl === 1'b1) begin
            starts++;
            active = 1'b1;
            rx = 1'b1;
            done = 1'b0;
            bitn = 0;
            nbyte = 0;
        end
    end
    always @(posedge sda) begin
        #1;
        if (scl === 1'b1) active = 1'b0;
    end
    always @(posedge scl) if (active) begin
        if (bitn < 8 && rx) sh = {sh[6:0], sda};
        if (bitn == 8 && !rx) mack = !sda;
        bitn++;
    end
    always @(negedge scl) if (active) begin
        if (bitn == 8) begin
            if (rx && nbyte == 0) begin
                adr = sh;
                if (!sh[0]) wr_addr = sh;
                sda_oe = !nack_addr;
            end else if (rx) begin
                word_addr = sh;
                ptr = int'(sh);
                sda_oe = 1'b1;
            end else sda_oe = 1'b0;
            if (rx) nbyte++;
        end else if (bitn == 9) begin
            bitn = 0;
            if (rx) rx = !(nbyte == 1 && adr[0]);
            else if (mack) ptr++;
            else done = 1'b1;
            cur = {<<{img(ptr)}};
            sda_oe = !rx && !done && !cur[7];
        end else if (!rx && !done) sda_oe = !cur[7-bitn];
    end
    // A slow part holds the clock low after each falling edge
    always @(negedge scl) if (slow && active) begin
        scl_oe = 1'b1;
        #300;
        scl_oe = 1'b0;
    end
endmodule
